// ### design/dram_init_mode_setup.sv
/*
  Device-side power-up and mode-set logic of an eight-bank graphics DRAM:
  strap capture, init sequence tracking, mode words, burst timing, APB view.
  Assumes controller pins arrive asynchronously and APB runs on pclk.
*/
`timescale 1ns/1ps
`include "dram_init_cfg.svh"
module dram_init_mode_setup
  import dram_init_pkg::*;
(
  // Clock and reset.
  input  logic        pclk,
  input  logic        presetn,
  // APB slave.
  input  logic [11:0] paddr,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // Controller pins.
  input  pins_t       pins,
  // Device state.
  output beat_t       rd_beat,
  output beat_t       wr_beat,
  output logic        rx_enable,
  output logic        dev_ready,
  output logic [1:0]  ca_term,
  output logic [1:0]  dq_term
);

  // ----------------------------------------------------------------
  // Pin synchroniser.
  // ----------------------------------------------------------------
  pins_t sync1_q;  // First stage, read only by the second.
  pins_t pins_q;   // Settled pin levels.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= PINS_IDLE;
      pins_q  <= PINS_IDLE;
    end else begin
      sync1_q <= pins;
      pins_q  <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Reset pin edge and strap capture.
  // ----------------------------------------------------------------
  logic       rst_pin_q;  // Reset pin level one edge ago.
  logic [1:0] strap_q;    // Latched {cke_n, A0}.

  wire rst_rise = pins_q.reset_n & ~rst_pin_q;

  // Straps and reset pass the same stages, so they are seen together.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pin_q <= 1'b0;
      strap_q   <= 2'b00;
    end else begin
      rst_pin_q <= pins_q.reset_n;
      if (rst_rise) begin
        strap_q <= {pins_q.cke_n, pins_q.addr[0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Command capture over two edges.
  // ----------------------------------------------------------------
  logic       half_q;  // First half taken, command fires next edge.
  logic [3:0] cmd_q;
  logic [2:0] rsel_q;
  logic [6:0] alo_q;

  wire        live     = ~pins_q.cs_n & pins_q.reset_n;
  wire [12:0] cmd_addr = {pins_q.addr[5:0], alo_q};
  wire        is_idle  = half_q & (cmd_q == CMD_IDLE);
  wire        is_mode  = half_q & (cmd_q == CMD_MODE);
  wire        is_prech = half_q & (cmd_q == CMD_PREC);
  wire        is_refr  = half_q & (cmd_q == CMD_REFR);
  wire        is_rd    = half_q & (cmd_q == CMD_RD);
  wire        is_wr    = half_q & (cmd_q == CMD_WR);
  wire        is_work  = half_q & ~is_idle;

  // The second edge carries the upper address half.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
      cmd_q  <= CMD_IDLE;
      rsel_q <= 3'd0;
      alo_q  <= 7'h00;
    end else begin
      half_q <= live & ~half_q;
      if (live & ~half_q) begin
        cmd_q  <= {pins_q.cs_n, pins_q.ras_n, pins_q.cas_n, pins_q.we_n};
        rsel_q <= pins_q.rsel;
        alo_q  <= pins_q.addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interval timers.
  // ----------------------------------------------------------------
  logic [7:0] gap_cnt_q;   // Precharge, mode-set or refresh interval.
  logic [9:0] lock_cnt_q;  // Loop lock interval.
  logic [1:0] nop_cnt_q;   // Idle commands seen after wake.

  wire       gap_start = is_prech | is_mode | is_refr;
  wire [7:0] gap_load  = is_prech ? 8'(`PRECHARGE_CYC) :
                         is_mode  ? 8'(`MODE_SET_CYC) : 8'(`REFRESH_CYC);
  wire       gap_busy  = (gap_cnt_q != 8'd0);
  wire       lock_go   = rst_rise |
                         (is_mode & (rsel_q == 3'd0) & cmd_addr[`F_LOOP_RST]);
  wire       lock_done = (lock_cnt_q == 10'd0);
  wire       loop_clr  = (lock_cnt_q == 10'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt_q  <= 8'd0;
      lock_cnt_q <= 10'(`LOOP_LOCK_CYC);
      nop_cnt_q  <= 2'd0;
    end else begin
      if (gap_start) gap_cnt_q <= gap_load;
      else if (gap_busy) gap_cnt_q <= gap_cnt_q - 8'd1;
      if (lock_go) lock_cnt_q <= 10'(`LOOP_LOCK_CYC);
      else if (!lock_done) lock_cnt_q <= lock_cnt_q - 10'd1;
      if (rst_rise) nop_cnt_q <= 2'd0;
      else if (is_idle && nop_cnt_q != `NOP_MIN) nop_cnt_q <= nop_cnt_q + 2'd1;
    end
  end

  // ----------------------------------------------------------------
  // Mode words: base, first, second and third extended.
  // ----------------------------------------------------------------
  logic [12:0] word_q [4];  // Stored mode words.
  logic        prog_q [4];  // Word written since reset release.

  // Termination default never reads 00; a 00 strap falls back to 01.
  wire [1:0]  term_dflt = (strap_q == 2'b00) ? 2'b01 : strap_q;
  wire [12:0] ext1_dflt = {11'h000, term_dflt} << `F_TERM_LO;

  for (genvar w = 0; w < 4; w++) begin : g_word
    wire hit = is_mode & (rsel_q == 3'(w));
    // Reset release loads defaults; others stay unset until written.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        word_q[w] <= 13'h0000;
        prog_q[w] <= 1'b0;
      end else if (hit) begin
        word_q[w] <= cmd_addr;
        prog_q[w] <= 1'b1;
      end else if (rst_rise) begin
        word_q[w] <= (w == 1) ? ext1_dflt : 13'h0000;
        prog_q[w] <= 1'b0;
      end else if (w == 0 && loop_clr) begin
        word_q[w][`F_LOOP_RST] <= 1'b0;
      end
    end
  end

  wire [3:0] prog_all = {prog_q[3], prog_q[2], prog_q[1], prog_q[0]};
  wire [3:0] rl_code  = word_q[0][`F_RLAT_LO +: 4];
  wire [2:0] wr_code  = word_q[0][`F_WLAT_LO +: 3];
  wire [4:0] rlat     = {1'b0, rl_code} + `RLAT_BASE;
  wire [4:0] wlat     = (wr_code == 3'd0) ? 5'd1 : {2'b00, wr_code};
  wire       rx_hold  = (wlat <= `RX_ON_MAX);

  // ----------------------------------------------------------------
  // Init sequence tracker.
  // ----------------------------------------------------------------
  init_state_t state_q;
  init_state_t state_d;
  logic        seq_err;  // Command out of the init order.
  logic        ready_q;
  logic        rd_busy;
  logic        wr_busy;

  always_comb begin
    state_d = state_q;
    seq_err = 1'b0;
    case (state_q)
      ST_RESET: begin
        if (rst_rise) state_d = ST_WAKE;
      end
      ST_WAKE: begin
        if (is_prech && nop_cnt_q == `NOP_MIN) state_d = ST_PREC;
        else if (is_work) seq_err = 1'b1;
      end
      ST_PREC: begin
        if (!gap_busy) state_d = ST_MODE;
      end
      ST_MODE: begin
        if (is_refr && (&prog_all)) state_d = ST_REFR;
        else if (is_work && !is_mode) seq_err = 1'b1;
      end
      ST_REFR: begin
        if (is_refr) state_d = ST_SETTLE;
        else if (is_work) seq_err = 1'b1;
      end
      ST_SETTLE: begin
        if (!gap_busy && lock_done) state_d = ST_READY;
        else if (is_work) seq_err = 1'b1;
      end
      ST_READY: begin
        if (is_mode && (rd_busy || wr_busy)) seq_err = 1'b1;
      end
      default: state_d = ST_RESET;
    endcase
    if (!pins_q.reset_n) state_d = ST_RESET;
  end

  // Column commands are taken only once the device is ready.
  wire rd_go   = is_rd & ready_q;
  wire wr_go   = is_wr & ready_q;
  wire col_err = (is_rd | is_wr) & (|cmd_addr[2:0]);
  wire tim_err = is_work & gap_busy;
  wire use_err = ((is_rd | is_wr) & ~ready_q) | (rd_go & rd_busy) |
                 (wr_go & wr_busy);
  wire ev_err  = seq_err | col_err | tim_err | use_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_RESET;
      ready_q   <= 1'b0;
      rx_enable <= 1'b0;
    end else begin
      state_q   <= state_d;
      ready_q   <= (state_d == ST_READY);
      rx_enable <= rx_hold | wr_go | wr_busy;
    end
  end

  // ----------------------------------------------------------------
  // Burst sequencers; the low column bits are ignored.
  // ----------------------------------------------------------------
  burst_seq u_rd (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (rd_go),
    .lat      (rlat),
    .col_base (cmd_addr[9:3]),
    .beat     (rd_beat),
    .busy     (rd_busy)
  );

  burst_seq u_wr (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (wr_go),
    .lat      (wlat),
    .col_base (cmd_addr[9:3]),
    .beat     (wr_beat),
    .busy     (wr_busy)
  );

  // ----------------------------------------------------------------
  // APB slave: one wait-free access, answers from flops.
  // ----------------------------------------------------------------
  logic        ctrl_q;  // Error capture enable.
  logic        err_q;   // Sticky protocol error.
  logic [31:0] rd_mux;
  logic        hit_any;
  status_t     status_w;

  wire setup   = psel & ~penable;
  wire wr_xfer = psel & penable & pready & pwrite;
  wire ctrl_wr = wr_xfer & (paddr == `OFF_CTRL);
  wire err_clr = ctrl_wr & pwdata[1];

  assign status_w = '{zero: 19'h0, busy: rd_busy | wr_busy,
                      lock_done: lock_done, err: err_q, prog: prog_all,
                      strap: strap_q, ready: ready_q, state: state_q};

  // Address decode for reads; other offsets answer with an error.
  always_comb begin
    rd_mux  = 32'h0000_0000;
    hit_any = 1'b1;
    if (paddr == `OFF_STATUS) rd_mux = status_w;
    else if (paddr == `OFF_BASE) rd_mux = {19'h0, word_q[0]};
    else if (paddr == `OFF_EXT1) rd_mux = {19'h0, word_q[1]};
    else if (paddr == `OFF_EXT2) rd_mux = {19'h0, word_q[2]};
    else if (paddr == `OFF_EXT3) rd_mux = {19'h0, word_q[3]};
    else if (paddr == `OFF_CTRL) rd_mux = {31'h0, ctrl_q};
    else hit_any = 1'b0;
  end

  // A new error beats a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      ctrl_q  <= `CTRL_RST;
      err_q   <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      if (setup) prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      if (ctrl_wr) ctrl_q <= pwdata[0];
      err_q <= (ctrl_q & ev_err) | (err_q & ~err_clr);
    end
  end

  assign dev_ready = ready_q;
  assign ca_term   = strap_q;
  assign dq_term   = word_q[1][`F_TERM_LO +: 2];

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_strap_capture : assert property (
    rst_rise |=> strap_q == $past({pins_q.cke_n, pins_q.addr[0]}))
    else $error("Straps not latched at reset release.");
  a_ready_path : assert property (
    $rose(ready_q) |-> $past(state_q) == ST_SETTLE && $past(gap_cnt_q) == 8'd0)
    else $error("Ready before the refresh interval ended.");
  a_ready_lock : assert property (
    $rose(ready_q) |-> $past(lock_cnt_q) == 10'd0)
    else $error("Ready before loop lock.");
  a_base_select : assert property (
    (is_mode && rsel_q == 3'd0) |=> word_q[0] == $past(cmd_addr))
    else $error("Select zero did not load the base word.");
  a_loop_self_clear : assert property (
    (loop_clr && !is_mode) |=> !word_q[0][`F_LOOP_RST])
    else $error("Loop reset bit did not clear itself.");
  a_ext1_default : assert property (
    (rst_rise && !is_mode) |=> word_q[1][`F_TERM_LO +: 2] != 2'b00)
    else $error("Termination default reads 00.");
  a_ext3_default : assert property (
    (rst_rise && !is_mode) |=> !word_q[3][`F_LPTERM] && !prog_q[3])
    else $error("Third word low-power bit not cleared.");
  a_rx_always_on : assert property (
    rx_hold |=> rx_enable)
    else $error("Receivers off under short write latency.");

  c_reach_ready : cover property ($rose(ready_q));
  c_loop_clear  : cover property (loop_clr ##1 !word_q[0][`F_LOOP_RST]);
  c_read_burst  : cover property (rd_go ##[1:30] rd_beat.valid);

endmodule : dram_init_mode_setup

// ### shared/dram_init_cfg.svh
/*
  Constants of the init and mode-set block: register offsets, mode word
  field positions, reset values and timing counts.
  Assumes pclk at 200 MHz and inclusion by bare name.
*/
`ifndef DRAM_INIT_CFG_SVH
`define DRAM_INIT_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB slave.
// ----------------------------------------------------------------
`define OFF_STATUS 12'h000
`define OFF_BASE   12'h004
`define OFF_EXT1   12'h008
`define OFF_EXT2   12'h00c
`define OFF_EXT3   12'h010
`define OFF_CTRL   12'h014

// ----------------------------------------------------------------
// Mode word fields and reset values.
// ----------------------------------------------------------------
`define F_RLAT_LO  3
`define F_LOOP_RST 8
`define F_WLAT_LO  9
`define F_TERM_LO  2
`define F_LPTERM   5
`define RLAT_BASE  5'd7
`define RX_ON_MAX  5'd3
`define NOP_MIN    2'd2
`define CTRL_RST   1'b1

// ----------------------------------------------------------------
// Timing: figures in ns, counts derived and rounded up; the loop lock count is given directly in cycles.
// ----------------------------------------------------------------
`define CLK_NS        5
`define PRECHARGE_NS  15
`define MODE_SET_NS   10
`define REFRESH_NS    130
`define LOOP_LOCK_CYC 512
`define PRECHARGE_CYC ((`PRECHARGE_NS + `CLK_NS - 1) / `CLK_NS)
`define MODE_SET_CYC  ((`MODE_SET_NS + `CLK_NS - 1) / `CLK_NS)
`define REFRESH_CYC   ((`REFRESH_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### shared/dram_init_pkg.sv
/*
  Types of the init and mode-set block: pin bundle, commands, init states,
  burst beat and status word.
  Assumes the constants header for numeric values.
*/
package dram_init_pkg;

  // ----------------------------------------------------------------
  // Pin bundle from the memory controller.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       reset_n;  // Device reset pin.
    logic       cke_n;    // Clock enable, also a strap.
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [2:0] rsel;     // Register and bank select.
    logic [6:0] addr;     // Half address per edge.
  } pins_t;

  // Quiet level of the pins: reset low, no command.
  localparam pins_t PINS_IDLE = 14'h1f00;

  // Commands as {cs_n, ras_n, cas_n, we_n}.
  typedef enum logic [3:0] {
    CMD_MODE = 4'h0,
    CMD_REFR = 4'h1,
    CMD_PREC = 4'h2,
    CMD_ACT  = 4'h3,
    CMD_WR   = 4'h4,
    CMD_RD   = 4'h5,
    CMD_IDLE = 4'h7
  } cmd_t;

  // Init states, Gray coded along the path.
  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_WAKE   = 3'b001,
    ST_PREC   = 3'b011,
    ST_MODE   = 3'b010,
    ST_REFR   = 3'b110,
    ST_SETTLE = 3'b111,
    ST_READY  = 3'b101
  } init_state_t;

  // One burst beat.
  typedef struct packed {
    logic       valid;
    logic [9:0] col;
  } beat_t;

  // Status register layout.
  typedef struct packed {
    logic [18:0] zero;
    logic        busy;
    logic        lock_done;
    logic        err;
    logic [3:0]  prog;
    logic [1:0]  strap;
    logic        ready;
    logic [2:0]  state;
  } status_t;

endpackage : dram_init_pkg

// ### design/burst_seq.sv
/*
  Burst sequencer: waits the programmed latency after a column command,
  then steps eight beats through the aligned column block.
  Assumes lat is at least one and start comes from pclk logic.
*/
`timescale 1ns/1ps
module burst_seq
  import dram_init_pkg::*;
(
  // Clock and reset.
  input  logic       pclk,
  input  logic       presetn,
  // Request.
  input  logic       start,
  input  logic [4:0] lat,
  input  logic [6:0] col_base,
  // Beat stream.
  output beat_t      beat,
  output logic       busy
);

  logic [4:0] wait_q;   // Edges left before the first beat.
  logic [2:0] idx_q;    // Column offset inside the block.
  logic [6:0] base_q;   // Aligned block number.
  logic       valid_q;  // Beat in flight.
  logic [4:0] lat_q;    // Latency of the running burst, for checks.
  logic [4:0] since_q;  // Edges since the request, for checks.

  // A request while busy is refused; the top flags it.
  wire take  = start & ~busy;
  wire first = (wait_q == 5'd1);
  wire last  = valid_q & (idx_q == 3'd7);

  assign busy = (wait_q != 5'd0) | valid_q;
  assign beat = {valid_q, base_q, idx_q};

  // ----------------------------------------------------------------
  // Latency count and beat stepping.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q  <= 5'd0;
      idx_q   <= 3'd0;
      base_q  <= 7'h00;
      valid_q <= 1'b0;
    end else begin
      if (take) begin
        wait_q <= lat;
        base_q <= col_base;
      end else if (wait_q != 5'd0) begin
        wait_q <= wait_q - 5'd1;
      end
      if (first) begin
        valid_q <= 1'b1;
        idx_q   <= 3'd0;
      end else if (last) begin
        valid_q <= 1'b0;
      end else if (valid_q) begin
        idx_q <= idx_q + 3'd1;
      end
    end
  end

  // Helper counters read only by the checks below.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q   <= 5'd0;
      since_q <= 5'd0;
    end else if (take) begin
      lat_q   <= lat;
      since_q <= 5'd0;
    end else if (since_q != 5'h1f) begin
      since_q <= since_q + 5'd1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_burst_length : assert property (
    $rose(valid_q) |-> valid_q[*8] ##1 !valid_q)
    else $error("Burst did not last eight beats.");
  a_burst_block : assert property (
    (valid_q && $past(valid_q)) |->
      (base_q == $past(base_q)) && (idx_q == 3'($past(idx_q) + 3'd1)))
    else $error("Burst left its column block.");
  a_burst_start : assert property (
    $rose(valid_q) |-> idx_q == 3'd0)
    else $error("Burst did not start at offset zero.");
  a_burst_latency : assert property (
    $rose(valid_q) |-> since_q == lat_q)
    else $error("First beat not at the programmed latency.");

endmodule : burst_seq

// ### test/ctrl_model.sv
/*
  Memory controller model: reset pin, straps and two-edge commands.
  Assumes a free running pclk; the bench calls its tasks.
*/
`timescale 1ns/1ps
module ctrl_model
  import dram_init_pkg::*;
(
  // Clock.
  input  wire logic pclk,
  // Pins towards the device.
  output pins_t     pins
);
  // ----------------------------------------------------------------
  // Command issue.
  // ----------------------------------------------------------------
  localparam int HOLD = 4;  // Strap hold in cycles, a plain choice.
  initial pins = PINS_IDLE;

  // Low half with the command, high half deselected, then a gap.
  // The address toggles in the gap so a stale value is never seen.
  task automatic cmd(input cmd_t c, input logic [2:0] rs, input logic [12:0] a,
                     input int gap);
    @(posedge pclk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= c;
    pins.rsel <= rs;
    pins.addr <= a[6:0];
    @(posedge pclk);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hf;
    pins.addr <= {1'b0, a[12:7]};
    repeat (gap) begin
      @(posedge pclk);
      pins.addr <= ~pins.addr;
    end
  endtask : cmd

  // ----------------------------------------------------------------
  // Power-up sequence; gaps are longer than the minimum counts.
  // ----------------------------------------------------------------
  task automatic init(input logic [1:0] strap, input logic [12:0] base, ext1);
    pins <= PINS_IDLE;
    repeat (40000) @(posedge pclk);
    pins.cke_n   <= strap[1];
    pins.addr[0] <= strap[0];
    repeat (HOLD) @(posedge pclk);
    pins.reset_n <= 1'b1;
    repeat (HOLD) @(posedge pclk);
    pins.cke_n <= 1'b0;
    repeat (40000) @(posedge pclk);
    repeat (2) cmd(CMD_IDLE, 3'h0, 13'h0, 1);
    cmd(CMD_PREC, 3'h0, 13'h400, 4);
    cmd(CMD_MODE, 3'h0, base, 4);
    cmd(CMD_MODE, 3'h1, ext1, 4);
    cmd(CMD_MODE, 3'h2, 13'h0, 4);
    cmd(CMD_MODE, 3'h3, 13'h0, 4);
    repeat (2) cmd(CMD_REFR, 3'h0, 13'h0, 28);
  endtask : init
endmodule : ctrl_model

// ### test/test_dram_init_mode_setup.sv
/*
  Self-checking bench of the init and mode-set block.
  Assumes the controller model drives pins and APB answers on pclk.
*/
`timescale 1ns/1ps
`include "dram_init_cfg.svh"
module test_dram_init_mode_setup
  import dram_init_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, queues of expected results and counters.
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_enable, dev_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  ca_term, dq_term;
  pins_t       pins;
  beat_t       rd_beat, wr_beat;
  logic [32:0] q_apb[$];  // {pslverr, prdata} per transfer.
  logic [9:0]  q_rd[$], q_wr[$];  // Beat columns in order.
  int          error_cnt = 0, n_tests = 0;

  dram_init_mode_setup dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .rd_beat(rd_beat),
    .wr_beat(wr_beat), .rx_enable(rx_enable), .dev_ready(dev_ready),
    .ca_term(ca_term), .dq_term(dq_term));
  ctrl_model model (.pclk(pclk), .pins(pins));

  always #2.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Compare, verdict and APB transfer.
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [32:0] e, s);
    n_tests++;
    if (e !== s) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, e, s);
    end
  endtask : chk

  task automatic results;
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // Holds the request until pready is seen; writes expect zero data.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    q_apb.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 50) chk("apb_wait", 0, 1);
    if (i == 50) results();
    {psel, penable} <= 2'b00;
  endtask : apb

  // Watches outputs and pairs each result with the oldest note.
  always @(posedge pclk) begin
    if (pready === 1'b1)
      chk("apb", q_apb.size() ? q_apb.pop_front() : 'x, {pslverr, pwrite ? 32'h0 : prdata});
    if (rd_beat.valid === 1'b1)
      chk("rd_col", q_rd.size() ? q_rd.pop_front() : 'x, rd_beat.col);
    if (wr_beat.valid === 1'b1)
      chk("wr_col", q_wr.size() ? q_wr.pop_front() : 'x, wr_beat.col);
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    logic [3:0]  rl;
    logic [6:0]  blk;
    logic [1:0]  strap;
    logic [12:0] base, ext1;
    int          i;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(15));
    rl    = 4'($urandom_range(13));
    strap = 2'($urandom);
    blk   = 7'($urandom);
    // Write latency 5 keeps receivers off between writes.
    base  = {1'b0, 3'h5, 1'b1, 1'b0, rl, 3'h3};
    ext1  = {9'h0, 2'h2, 2'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFF_CTRL, 32'h0, {1'b0, 32'h1});
    apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
    model.init(strap, base, ext1);
    chk("early_ready", 1'b0, dev_ready);
    for (i = 0; i < 2000 && dev_ready !== 1'b1; i++) @(posedge pclk);
    chk("dev_ready", 1'b1, dev_ready);
    if (i == 2000) results();
    chk("ca_term", strap, ca_term);
    chk("dq_term", 2'h2, dq_term);
    chk("rx_off", 1'b0, rx_enable);
    apb(1'b0, `OFF_STATUS, 32'h0, {20'h0, 3'h2, 4'hf, strap, 4'hd});
    apb(1'b1, `OFF_BASE, 32'hffffffff, {1'b0, 32'h0});
    apb(1'b0, `OFF_BASE, 32'h0, {20'h0, base & 13'h1eff});
    apb(1'b0, `OFF_EXT1, 32'h0, {20'h0, ext1});
    for (i = 0; i < 8; i++) q_rd.push_back({blk, 3'(i)});
    model.cmd(CMD_RD, 3'h0, {3'h0, blk, 3'h0}, 40);
    for (i = 0; i < 8; i++) q_wr.push_back({~blk, 3'(i)});
    model.cmd(CMD_WR, 3'h1, {3'h0, ~blk, 3'h0}, 40);
    // Nonzero low column bits: the burst still starts at offset zero, err is flagged.
    for (i = 0; i < 8; i++) q_rd.push_back({7'h00, 3'(i)});
    model.cmd(CMD_RD, 3'h0, 13'h0001, 32);
    apb(1'b0, `OFF_STATUS, 32'h0, {20'h0, 3'h3, 4'hf, strap, 4'hd});
    apb(1'b1, `OFF_CTRL, 32'h2, {1'b0, 32'h0});
    apb(1'b0, `OFF_CTRL, 32'h0, {1'b0, 32'h0});
    apb(1'b0, `OFF_STATUS, 32'h0, {20'h0, 3'h2, 4'hf, strap, 4'hd});
    chk("beats_left", 0, q_rd.size() + q_wr.size());
    results();
  end
endmodule : test_dram_init_mode_setup
